// [inc/vrs_pkg.sv]
// Constants, types and state layout of the regulator mode sequencer.
// Behaviour
// - The all-ones voltage code runs the shutdown sequence like power-down low, but keeps the clock gate driven.
// - Leaving the all-ones code starts the same boot sequence as power-up.
// - In shutdown both low-side gates stay low and control is off.
// - After power-up wait for reference ready, then boot at quarter slew, pulse-skipping.
// - Low-power state low in normal run drops phase 3, floats its pin, skip low.
// - In run the target follows the current voltage code at nominal slew.
// - Deep-sleep high switches at once to single-phase pulse skipping.
// - In deep sleep the upper thresholds for good and clock gate are ignored.
// - Deep sleep turns phase 2 gates off, floats phase-3 pin, drives skip low.
// - Power-down falling drops good, floats clock gate, forces all phases, quarter slew.
// - Shutdown ramps to 12.5 mV, then all gates low and discharge on.
// - Undervoltage, overvoltage or thermal trip latches a fault that stops switching.
// - Only a power-down toggle or supply cycle clears the fault latch.
// - A voltage code change in run starts a move; host changes all bits together.
package vrs_pkg;
   localparam int CLK_MHZ = 125;
   localparam int STEP_TIME_NS = 1000;
   localparam int STEP_CYC = (STEP_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] STEP_CYC_RST = 8'(STEP_CYC);
   localparam logic [6:0] OFF_CODE = 7'h7f;
   localparam logic [6:0] ZERO_CODE = 7'h78;
   localparam logic [6:0] FINAL_CODE = 7'h77;
   localparam logic [6:0] BOOT_CODE_RST = 7'h20;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
   localparam int CTRL_STEP_LSB = 0;
   localparam int CTRL_BOOT_LSB = 8;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_TGT_LSB = 3;
   localparam int STAT_FAULT_BIT = 10;
   localparam int STAT_GOOD_BIT = 11;
   localparam int STAT_CODE_LSB = 12;
   localparam int IRQ_W = 5;
   localparam int IRQ_FAULT = 0;
   localparam int IRQ_BOOT = 1;
   localparam int IRQ_DOWN = 2;
   localparam int IRQ_CODE = 3;
   localparam int IRQ_GOOD_FALL = 4;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   typedef enum logic [2:0] {
      ST_SHUTDOWN = 3'b000,
      ST_WAIT_REF = 3'b001,
      ST_BOOT = 3'b010,
      ST_RUN = 3'b011,
      ST_RAMP_DOWN = 3'b100,
      ST_OFF = 3'b101,
      ST_FAULT = 3'b110
   } vrs_state_t;

   typedef struct packed {
      logic power_down_n;
      logic deep_sleep;
      logic low_power_n;
      logic [6:0] code;
      logic ref_ready;
      logic upper_trip;
      logic uv;
      logic ov;
      logic thermal;
   } vrs_pins_t;

   typedef struct packed {
      logic good;
      logic clk_n;
      logic clk_oe;
      logic ext_pwm;
      logic ext_oe;
      logic skip_n;
      logic p1_high;
      logic p1_low;
      logic p2_high;
      logic p2_low;
      logic discharge;
      logic quarter;
      logic pskip;
   } vrs_drive_t;

   localparam vrs_drive_t DRV_RESET = '{good: 1'b0, clk_n: 1'b0,
      clk_oe: 1'b0, ext_pwm: 1'b0, ext_oe: 1'b0, skip_n: 1'b1,
      p1_high: 1'b0, p1_low: 1'b0, p2_high: 1'b0, p2_low: 1'b0,
      discharge: 1'b1, quarter: 1'b0, pskip: 1'b0};

   typedef struct packed {
      vrs_state_t state;
      logic cause_off;
      logic fault;
      logic pd_prev;
      logic [6:0] code_prev;
      logic [6:0] target;
      logic [9:0] step_cnt;
      logic [7:0] step_cycles;
      logic [6:0] boot_code;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_en;
      logic a_valid;
      logic a_write;
      logic [7:0] a_addr;
      logic [31:0] hrdata;
      vrs_drive_t drv;
   } vrs_seq_reg_t;

   localparam vrs_seq_reg_t SEQ_RESET = '{state: ST_SHUTDOWN,
      cause_off: 1'b0, fault: 1'b0, pd_prev: 1'b0, code_prev: OFF_CODE,
      target: ZERO_CODE, step_cnt: 10'h000, step_cycles: STEP_CYC_RST,
      boot_code: BOOT_CODE_RST, irq_status: 5'h00, irq_en: 5'h00,
      a_valid: 1'b0, a_write: 1'b0, a_addr: 8'h00, hrdata: 32'h0000_0000,
      drv: DRV_RESET};
endpackage

// [hw/vrs_sync.sv]
// Two-stage synchroniser for the asynchronous regulator pins.
`timescale 1ns/10ps
`default_nettype none
module vrs_sync
   import vrs_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } vrs_sync_reg_t;

   vrs_sync_reg_t s;
   vrs_sync_reg_t next_s;

   // The first stage feeds only the second stage.
   always_comb begin
      next_s = s;
      for (int i = 0; i < W; i++) begin
         next_s.meta[i] = async_in[i];
         next_s.stable[i] = s.meta[i];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.stable;
endmodule
`default_nettype wire

// [hw/vrs_sequencer.sv]
// Operating-mode sequencer of a multiphase core regulator, AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
module vrs_sequencer
   import vrs_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   input wire logic power_down_n_in,
   input wire logic deep_sleep_req,
   input wire logic low_power_state_n,
   input wire logic [6:0] voltage_code_bits,
   input wire logic ref_ready_in,
   input wire logic upper_trip_in,
   input wire logic undervoltage_trip,
   input wire logic overvoltage_trip,
   input wire logic thermal_trip,
   output logic output_good,
   output logic clock_gate_n_out,
   output logic clock_gate_oe,
   output logic ext_phase_pwm_out,
   output logic ext_phase_pwm_oe,
   output logic ext_skip_n_out,
   output logic phase1_high_gate,
   output logic phase1_low_gate,
   output logic phase2_high_gate,
   output logic phase2_low_gate,
   output logic output_discharge_node,
   output logic quarter_slew,
   output logic pulse_skip_mode,
   output logic [6:0] target_code
);
   vrs_pins_t pins_raw;
   vrs_pins_t pins;
   vrs_seq_reg_t s;
   vrs_seq_reg_t next_s;
   vrs_drive_t d;
   logic rise, fall, fault_in, code_off, tick, addr_ph, stay_run;
   logic [9:0] rate;
   logic [6:0] goal;
   logic [IRQ_W-1:0] ev;
   logic [IRQ_W-1:0] clr;
   logic [31:0] rd;

   assign pins_raw = '{power_down_n: power_down_n_in,
      deep_sleep: deep_sleep_req, low_power_n: low_power_state_n,
      code: voltage_code_bits, ref_ready: ref_ready_in,
      upper_trip: upper_trip_in, uv: undervoltage_trip,
      ov: overvoltage_trip, thermal: thermal_trip};

   vrs_sync #(.W($bits(vrs_pins_t))) u_sync (
      .mclk(mclk),
      .srst(srst),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   assign rise = pins.power_down_n & ~s.pd_prev;
   assign fall = ~pins.power_down_n & s.pd_prev;
   assign fault_in = pins.uv | pins.ov | pins.thermal;
   assign code_off = pins.code == OFF_CODE;
   assign rate = s.drv.quarter ? {s.step_cycles, 2'b00}
                               : {2'b00, s.step_cycles};
   assign tick = s.step_cnt == 10'h000;
   assign addr_ph = hsel & htrans[1] & hready;
   assign stay_run = (s.state == ST_RUN) & pins.power_down_n & ~fault_in
                     & ~code_off;

   always_comb begin
      rd = 32'h0000_0000;
      case (haddr[7:0])
         ADDR_CTRL: begin
            rd[CTRL_STEP_LSB +: 8] = s.step_cycles;
            rd[CTRL_BOOT_LSB +: 7] = s.boot_code;
         end
         ADDR_STATUS: begin
            rd[STAT_STATE_LSB +: 3] = s.state;
            rd[STAT_TGT_LSB +: 7] = s.target;
            rd[STAT_FAULT_BIT] = s.fault;
            rd[STAT_GOOD_BIT] = s.drv.good;
            rd[STAT_CODE_LSB +: 7] = pins.code;
         end
         ADDR_IRQ_STATUS: rd[IRQ_W-1:0] = s.irq_status;
         ADDR_IRQ_EN: rd[IRQ_W-1:0] = s.irq_en;
         default: rd = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_s = s;
      ev = '0;
      clr = '0;
      d = DRV_RESET;
      goal = s.target;
      next_s.pd_prev = pins.power_down_n;
      // Mode and sequence decisions; shutdown, power-down falling and fault come first.
      if (s.state == ST_SHUTDOWN) begin
         if (rise) begin
            next_s.state = ST_WAIT_REF;
            next_s.fault = 1'b0;
         end
      end else if (fall) begin
         next_s.fault = 1'b0;
         next_s.cause_off = 1'b0;
         next_s.state = (s.state == ST_FAULT) ? ST_SHUTDOWN
                                              : ST_RAMP_DOWN;
      end else if (fault_in && s.state != ST_FAULT) begin
         next_s.state = ST_FAULT;
         next_s.fault = 1'b1;
         ev[IRQ_FAULT] = 1'b1;
      end else begin
         unique case (s.state)
            ST_WAIT_REF: begin
               if (code_off) begin
                  next_s.state = ST_OFF;
               end else if (pins.ref_ready) begin
                  next_s.state = ST_BOOT;
               end
            end
            ST_BOOT: begin
               if (code_off) begin
                  next_s.state = ST_RAMP_DOWN;
                  next_s.cause_off = 1'b1;
               end else if (s.target == s.boot_code) begin
                  next_s.state = ST_RUN;
                  ev[IRQ_BOOT] = 1'b1;
               end
            end
            ST_RUN: begin
               if (code_off) begin
                  next_s.state = ST_RAMP_DOWN;
                  next_s.cause_off = 1'b1;
               end
            end
            ST_RAMP_DOWN: begin
               if (s.target >= FINAL_CODE) begin
                  ev[IRQ_DOWN] = 1'b1;
                  if (s.cause_off) begin
                     next_s.state = ST_OFF;
                  end else if (pins.power_down_n) begin
                     next_s.state = ST_WAIT_REF;
                  end else begin
                     next_s.state = ST_SHUTDOWN;
                  end
               end
            end
            ST_OFF: begin
               if (!code_off) begin
                  next_s.state = ST_WAIT_REF;
               end
            end
            ST_SHUTDOWN, ST_FAULT: begin
            end
            default: next_s.state = ST_SHUTDOWN;
         endcase
      end

      // Pin levels for the state entered at this edge.
      unique case (next_s.state)
         ST_SHUTDOWN: begin
            d.discharge = 1'b1;
            goal = ZERO_CODE;
         end
         ST_WAIT_REF, ST_OFF, ST_FAULT: begin
            d.discharge = next_s.state == ST_OFF;
            d.clk_n = 1'b1;
            d.clk_oe = 1'b1;
            goal = (next_s.state == ST_FAULT) ? s.target : ZERO_CODE;
         end
         ST_BOOT: begin
            d = '{good: 1'b0, clk_n: 1'b1, clk_oe: 1'b1, ext_pwm: 1'b1,
               ext_oe: 1'b1, skip_n: 1'b0, p1_high: 1'b1, p1_low: 1'b1,
               p2_high: 1'b1, p2_low: 1'b1, discharge: 1'b0,
               quarter: 1'b1, pskip: 1'b1};
            goal = s.boot_code;
         end
         ST_RUN: begin
            d.discharge = 1'b0;
            d.clk_oe = 1'b1;
            d.p1_high = 1'b1;
            d.p1_low = 1'b1;
            goal = pins.code;
            if (pins.deep_sleep) begin
               d.pskip = 1'b1;
               d.skip_n = 1'b0;
            end else if (!pins.low_power_n) begin
               d.p2_high = 1'b1;
               d.p2_low = 1'b1;
               d.skip_n = 1'b0;
            end else begin
               d.p2_high = 1'b1;
               d.p2_low = 1'b1;
               d.ext_pwm = 1'b1;
               d.ext_oe = 1'b1;
            end
            d.good = (s.target == pins.code)
                     & (pins.deep_sleep | ~pins.upper_trip);
            d.clk_n = ~d.good;
         end
         ST_RAMP_DOWN: begin
            d = '{good: 1'b0, clk_n: 1'b1, clk_oe: next_s.cause_off,
               ext_pwm: 1'b1, ext_oe: 1'b1, skip_n: 1'b1, p1_high: 1'b1,
               p1_low: 1'b1, p2_high: 1'b1, p2_low: 1'b1, discharge: 1'b0,
               quarter: 1'b1, pskip: 1'b0};
            goal = FINAL_CODE;
         end
         default: d = DRV_RESET;
      endcase
      next_s.drv = d;

      // Target steps one code per slew interval toward its goal.
      if (tick) begin
         next_s.step_cnt = (rate == 10'h000) ? 10'h000 : rate - 10'h001;
         if (s.target > goal) begin
            next_s.target = s.target - 7'h01;
         end else if (s.target < goal) begin
            next_s.target = s.target + 7'h01;
         end
      end else begin
         next_s.step_cnt = s.step_cnt - 10'h001;
      end
      if (next_s.state == ST_SHUTDOWN || next_s.state == ST_OFF
          || next_s.state == ST_WAIT_REF) begin
         next_s.target = ZERO_CODE;
      end

      next_s.code_prev = pins.code;
      // Both power-down samples high, so the synchroniser flush after reset
      // is not taken for a code change.
      if (pins.code != s.code_prev && pins.power_down_n && s.pd_prev) begin
         ev[IRQ_CODE] = 1'b1;
      end
      if (s.drv.good && !d.good) begin
         ev[IRQ_GOOD_FALL] = 1'b1;
      end

      // Bus slave: address phase captured, write applied in data phase.
      next_s.a_valid = addr_ph;
      if (addr_ph) begin
         next_s.a_write = hwrite & (hsize == SIZE_WORD);
         next_s.a_addr = haddr[7:0];
         next_s.hrdata = hwrite ? 32'h0000_0000 : rd;
      end
      if (s.a_valid && s.a_write) begin
         case (s.a_addr)
            ADDR_CTRL: begin
               next_s.step_cycles = hwdata[CTRL_STEP_LSB +: 8];
               next_s.boot_code = hwdata[CTRL_BOOT_LSB +: 7];
            end
            ADDR_IRQ_CLEAR: clr = hwdata[IRQ_W-1:0];
            ADDR_IRQ_EN: next_s.irq_en = hwdata[IRQ_W-1:0];
            default: next_s.irq_en = s.irq_en;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      next_s.irq_status = (s.irq_status & ~clr) | ev;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s <= SEQ_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.hrdata;
   assign irq = |(s.irq_status & s.irq_en);
   assign output_good = s.drv.good;
   assign clock_gate_n_out = s.drv.clk_n;
   assign clock_gate_oe = s.drv.clk_oe;
   assign ext_phase_pwm_out = s.drv.ext_pwm;
   assign ext_phase_pwm_oe = s.drv.ext_oe;
   assign ext_skip_n_out = s.drv.skip_n;
   assign phase1_high_gate = s.drv.p1_high;
   assign phase1_low_gate = s.drv.p1_low;
   assign phase2_high_gate = s.drv.p2_high;
   assign phase2_low_gate = s.drv.p2_low;
   assign output_discharge_node = s.drv.discharge;
   assign quarter_slew = s.drv.quarter;
   assign pulse_skip_mode = s.drv.pskip;
   assign target_code = s.target;

   default clocking @(posedge mclk); endclocking
   default disable iff (srst);

   property p_off_gates;
      s.state == ST_SHUTDOWN |-> !phase1_low_gate && !phase2_low_gate;
   endproperty
   a_off_gates: assert property (p_off_gates)
      else $error("low-side gate on in shutdown");

   property p_off_code_ramp;
      (s.state == ST_RUN && pins.power_down_n && !fault_in && code_off)
         |=> s.state == ST_RAMP_DOWN && s.cause_off && clock_gate_oe;
   endproperty
   a_off_code_ramp: assert property (p_off_code_ramp)
      else $error("off code did not start the shutdown ramp");

   property p_off_exit;
      (s.state == ST_OFF && pins.power_down_n && !fault_in && !code_off)
         |=> s.state == ST_WAIT_REF;
   endproperty
   a_off_exit: assert property (p_off_exit)
      else $error("leaving off code did not boot");

   property p_ref_wait;
      (s.state == ST_WAIT_REF && !pins.ref_ready && pins.power_down_n
       && !fault_in && !code_off) |=> s.state == ST_WAIT_REF
         && !phase1_high_gate;
   endproperty
   a_ref_wait: assert property (p_ref_wait)
      else $error("boot started before reference ready");

   property p_boot_mode;
      s.state == ST_BOOT |-> quarter_slew && pulse_skip_mode
         && !ext_skip_n_out && ext_phase_pwm_oe;
   endproperty
   a_boot_mode: assert property (p_boot_mode)
      else $error("boot not in quarter-slew pulse skipping");

   property p_reduced;
      stay_run && !pins.deep_sleep && !pins.low_power_n
         |=> !ext_phase_pwm_oe && !ext_skip_n_out && phase2_low_gate;
   endproperty
   a_reduced: assert property (p_reduced)
      else $error("low-power state did not drop phase 3");

   property p_deep;
      stay_run && pins.deep_sleep |=> !phase2_high_gate
         && !phase2_low_gate && !ext_phase_pwm_oe && !ext_skip_n_out
         && pulse_skip_mode;
   endproperty
   a_deep: assert property (p_deep)
      else $error("deep sleep phase pattern wrong");

   property p_blank;
      stay_run && pins.deep_sleep && pins.upper_trip
         && s.target == pins.code |=> output_good && !clock_gate_n_out;
   endproperty
   a_blank: assert property (p_blank)
      else $error("upper threshold not blanked in deep sleep");

   property p_fall;
      fall && s.state != ST_SHUTDOWN && s.state != ST_FAULT
         |=> !output_good && !clock_gate_oe && s.state == ST_RAMP_DOWN
         && quarter_slew && phase2_high_gate;
   endproperty
   a_fall: assert property (p_fall)
      else $error("falling power-down handled wrong");

   property p_ramp_end;
      s.state == ST_RAMP_DOWN && s.target < FINAL_CODE
         |=> !output_discharge_node;
   endproperty
   a_ramp_end: assert property (p_ramp_end)
      else $error("discharge before the final step");

   property p_discharge;
      output_discharge_node |-> !phase1_high_gate && !phase1_low_gate
         && !phase2_high_gate && !phase2_low_gate;
   endproperty
   a_discharge: assert property (p_discharge)
      else $error("gate on while discharging");

   property p_fault_hold;
      s.state == ST_FAULT && pins.power_down_n |=> s.state == ST_FAULT
         && s.fault && !phase1_low_gate;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault released without power-down toggle");

   property p_rise;
      s.state == ST_SHUTDOWN && rise |=> s.state == ST_WAIT_REF
         && !s.fault;
   endproperty
   a_rise: assert property (p_rise)
      else $error("rising power-down not taken next cycle");

   c_boot_done: cover property (s.state == ST_BOOT ##1 s.state == ST_RUN);
   c_off_code: cover property (s.state == ST_RAMP_DOWN ##1 s.state == ST_OFF);
   c_deep: cover property (stay_run && pins.deep_sleep);
   c_fault: cover property (s.state == ST_FAULT);
endmodule
`default_nettype wire

// [tb/vrs_host_model.sv]
// Host processor model that drives the voltage code and sleep pins.
`timescale 1ns/10ps
`default_nettype none
module vrs_host_model
   import vrs_pkg::*;
(
   input wire logic mclk,
   output logic power_down_n_in,
   output logic deep_sleep_req,
   output logic low_power_state_n,
   output logic [6:0] voltage_code_bits
);
   initial begin
      power_down_n_in = 1'b0;
      deep_sleep_req = 1'b0;
      low_power_state_n = 1'b1;
      voltage_code_bits = BOOT_CODE_RST;
   end

   // All code bits change on the same edge, so no mixed code is seen.
   task drive(input logic pd, input logic ds, input logic lp,
              input logic [6:0] c);
      @(posedge mclk);
      power_down_n_in <= pd;
      deep_sleep_req <= ds;
      low_power_state_n <= lp;
      voltage_code_bits <= c;
   endtask
endmodule
`default_nettype wire

// [tb/vrs_sequencer_test.sv]
// Self-checking testbench of the regulator mode sequencer.
`timescale 1ns/10ps
`default_nettype none
module vrs_sequencer_test
   import vrs_pkg::*;
;
   logic mclk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic ref_ok = 1'b0, upper = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = SIZE_WORD, trip = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, irq, output_good, clock_gate_n_out, clock_gate_oe;
   logic ext_phase_pwm_out, ext_phase_pwm_oe, ext_skip_n_out;
   logic phase1_high_gate, phase1_low_gate, phase2_high_gate;
   logic phase2_low_gate, output_discharge_node, quarter_slew;
   logic pulse_skip_mode, pd_n, ds, lp_n;
   logic [6:0] target_code, code;
   int mismatches = 0, checked = 0;

   always #4 mclk = ~mclk;

   vrs_host_model i_vrs_host_model (.mclk(mclk), .power_down_n_in(pd_n),
      .deep_sleep_req(ds), .low_power_state_n(lp_n),
      .voltage_code_bits(code));

   vrs_sequencer i_vrs_sequencer (.mclk(mclk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .irq(irq), .power_down_n_in(pd_n),
      .deep_sleep_req(ds), .low_power_state_n(lp_n),
      .voltage_code_bits(code), .ref_ready_in(ref_ok),
      .upper_trip_in(upper), .undervoltage_trip(trip[0]),
      .overvoltage_trip(trip[1]), .thermal_trip(trip[2]),
      .output_good(output_good), .clock_gate_n_out(clock_gate_n_out),
      .clock_gate_oe(clock_gate_oe), .ext_phase_pwm_out(ext_phase_pwm_out),
      .ext_phase_pwm_oe(ext_phase_pwm_oe), .ext_skip_n_out(ext_skip_n_out),
      .phase1_high_gate(phase1_high_gate), .phase1_low_gate(phase1_low_gate),
      .phase2_high_gate(phase2_high_gate), .phase2_low_gate(phase2_low_gate),
      .output_discharge_node(output_discharge_node),
      .quarter_slew(quarter_slew), .pulse_skip_mode(pulse_skip_mode),
      .target_code(target_code));

   task report_and_stop;
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      int n;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= SIZE_WORD;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask

   // Polls the state field of the status word, bounded.
   task wait_state(input vrs_state_t s);
      logic [31:0] x;
      int n;
      n = 0;
      do begin
         bus(1'b0, ADDR_STATUS, 32'h0, x);
         n++;
      end while (x[2:0] !== s && n < 2000);
      if (n >= 2000) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task wait_tgt(input logic [6:0] c);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (target_code !== c && n < 3000);
      if (n >= 3000) begin
         mismatches++;
         report_and_stop();
      end
   endtask

   task settle;
      repeat (5) @(posedge mclk);
   endtask

   initial begin
      logic [31:0] d;
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      rdchk(ADDR_CTRL, {17'h0, BOOT_CODE_RST, 8'h7d});
      chk({output_good, clock_gate_oe, output_discharge_node, phase1_low_gate,
         phase2_low_gate, target_code}, {5'b00100, ZERO_CODE});
      chk({hreadyout, hresp}, 2'b10);
      wr(ADDR_CTRL, {17'h0, BOOT_CODE_RST, 8'h02});
      wr(8'h20, 32'hffff_ffff);
      rdchk(8'h20, 32'h0);
      wr(ADDR_IRQ_EN, 32'h1f);
      rdchk(ADDR_IRQ_EN, 32'h1f);
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, BOOT_CODE_RST);
      wait_state(ST_WAIT_REF);
      settle;
      bus(1'b0, ADDR_STATUS, 32'h0, d);
      chk(d[2:0], 3'(ST_WAIT_REF));
      ref_ok <= 1'b1;
      settle;
      chk({quarter_slew, pulse_skip_mode}, 2'b11);
      wait_state(ST_RUN);
      chk({target_code, irq}, {BOOT_CODE_RST, 1'b1});
      wr(ADDR_IRQ_CLEAR, 32'h1f);
      wr(ADDR_IRQ_EN, 32'h0);
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, 7'h30);
      wait_tgt(7'h30);
      settle;
      chk({quarter_slew, pulse_skip_mode, output_good, ext_phase_pwm_oe,
         ext_phase_pwm_out, ext_skip_n_out, irq}, 7'b0011110);
      rdchk(ADDR_IRQ_STATUS, 32'h18);
      wr(ADDR_IRQ_EN, 32'h08);
      @(posedge mclk);
      chk(irq, 1'b1);
      wr(ADDR_IRQ_CLEAR, 32'h1f);
      rdchk(ADDR_IRQ_STATUS, 32'h0);
      chk(irq, 1'b0);
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b0, 7'h30);
      settle;
      chk({ext_phase_pwm_oe, ext_skip_n_out, pulse_skip_mode}, 3'b000);
      upper <= 1'b1;
      settle;
      chk({output_good, clock_gate_n_out}, 2'b01);
      i_vrs_host_model.drive(1'b1, 1'b1, 1'b0, 7'h30);
      settle;
      chk({pulse_skip_mode, phase2_high_gate, phase2_low_gate,
         ext_phase_pwm_oe, ext_skip_n_out, output_good}, 6'b100001);
      upper <= 1'b0;
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, OFF_CODE);
      wait_state(ST_OFF);
      chk({output_good, clock_gate_n_out, clock_gate_oe, output_discharge_node,
         phase1_high_gate, phase1_low_gate}, 6'b011100);
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, 7'h28);
      wait_state(ST_BOOT);
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, OFF_CODE);
      wait_state(ST_OFF);
      i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, 7'h28);
      wait_state(ST_RUN);
      wait_tgt(7'h28);
      for (int k = 0; k < 3; k++) begin
         trip <= 3'h1 << k;
         wait_state(ST_FAULT);
         trip <= 3'h0;
         i_vrs_host_model.drive(1'b1, 1'b1, 1'b1, 7'h30);
         settle;
         bus(1'b0, ADDR_STATUS, 32'h0, d);
         chk({d[2:0], d[STAT_FAULT_BIT]}, {3'(ST_FAULT), 1'b1});
         chk({phase1_high_gate, phase1_low_gate, phase2_high_gate,
            phase2_low_gate}, 4'h0);
         bus(1'b0, ADDR_IRQ_STATUS, 32'h0, d);
         chk(d[IRQ_FAULT], 1'b1);
         wr(ADDR_IRQ_CLEAR, 32'h1f);
         i_vrs_host_model.drive(1'b0, 1'b0, 1'b1, 7'h28);
         wait_state(ST_SHUTDOWN);
         i_vrs_host_model.drive(1'b1, 1'b0, 1'b1, 7'h28);
         wait_state(ST_RUN);
      end
      wait_tgt(7'h28);
      i_vrs_host_model.drive(1'b0, 1'b0, 1'b1, 7'h28);
      settle;
      chk({output_good, clock_gate_oe, quarter_slew, pulse_skip_mode,
         output_discharge_node}, 5'b00100);
      wait_state(ST_SHUTDOWN);
      chk({phase1_high_gate, phase1_low_gate, phase2_high_gate,
         phase2_low_gate, output_discharge_node, target_code},
         {5'b00001, ZERO_CODE});
      report_and_stop();
   end
endmodule
`default_nettype wire
